// file: design/ctd_pkg.sv
// Constants, register map and carrier types for the copper test and diagnostics registers
// Summary of operation
// RULE1 - Generator gap length in bytes is gap field plus one; field resets to twelve
// RULE2 - Half duplex: receive start during transmit bytes 65..96 bumps counter one
// RULE3 - Half duplex: receive start during transmit bytes 97..128 bumps counter two
// RULE4 - Half duplex: receive start during transmit bytes 129..192 bumps counter three
// RULE5 - Half duplex: receive start after 192 transmit bytes bumps counter four
// RULE6 - Collision timing is judged at the internal gigabit interface byte position
// RULE7 - Collision counters saturate at maximum and clear to zero when read
// RULE8 - Window adjust moves the first window start earlier by its value in bytes
// RULE9 - Polling code 00 one second, 01 ten milliseconds, 1x polling off
// RULE10 - Threshold in Celsius is five times field minus 25; resets to 0x19
// RULE11 - Interrupt enable bit lets the temperature event reach the interrupt
// RULE12 - Status bit latches high when temperature reaches threshold
// RULE13 - Manual bit drives sensor acquire, only when the select field is binary 10
// RULE14 - Coarse readout returns bits 5..1 of the temperature value
// RULE15 - Averaging code picks 2^9, 2^11, 2^13 or 2^15 samples; resets to 01
// RULE16 - Sampling interval code picks one of eight periods; resets to 100
// RULE17 - Alternative readout is Celsius plus 25 as an eight bit value
// RULE18 - Software writes the top reserved control bit only with its reset value
// RULE19 - Interrupt output high while status and enable are both set; the code registers it, so it follows them one cycle later
// RULE20 - Status clears on read and sets again if still at threshold
// RULE21 - Increment in the same cycle as a clearing read leaves the counter at one
package ctd_pkg;
   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [4:0] ADDR_GAP = 5'h13;
   localparam logic [4:0] ADDR_LC_LO = 5'h17;
   localparam logic [4:0] ADDR_LC_HI = 5'h18;
   localparam logic [4:0] ADDR_WIN = 5'h19;
   localparam logic [4:0] ADDR_TCTL = 5'h1a;
   localparam logic [4:0] ADDR_TALT = 5'h1b;
   localparam logic [15:0] GAP_RST = 16'h000c;
   localparam logic [15:0] WIN_RST = 16'h0000;
   localparam logic [15:0] TCTL_RST = 16'h1900;
   localparam logic [15:0] TALT_RST = 16'h0c00;
   // Status bit 6 and readout 4:0 are not stored from writes
   localparam logic [15:0] TCTL_WMASK = 16'hffa0;
   localparam logic [15:0] TALT_WMASK = 16'hff00;
   localparam int WIN_ADJ_LSB = 8;
   localparam int POLL_LSB = 13;
   localparam int THR_LSB = 8;
   localparam int IEN_BIT = 7;
   localparam int STAT_BIT = 6;
   localparam int MAN_BIT = 5;
   localparam int AVG_LSB = 11;
   localparam int SRATE_LSB = 8;
   localparam logic [1:0] MANUAL_SEL = 2'h2;
   localparam logic [1:0] POLL_1S = 2'h0;
   // ------------------------------------------------------------
   // Collision window byte bounds
   // ------------------------------------------------------------
   localparam logic [8:0] WIN1_FIRST = 9'h041;
   localparam logic [8:0] WIN1_LAST = 9'h060;
   localparam logic [8:0] WIN2_LAST = 9'h080;
   localparam logic [8:0] WIN3_LAST = 9'h0c0;
   localparam logic [7:0] TEMP_MULT = 8'h05;
   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam longint CLK_PERIOD_NS = 40;
   localparam longint POLL_SLOW_NS = 1000000000;
   localparam longint POLL_FAST_NS = 10000000;
   localparam longint POLL_SLOW_CYC = POLL_SLOW_NS / CLK_PERIOD_NS;
   localparam longint POLL_FAST_CYC = POLL_FAST_NS / CLK_PERIOD_NS;
   localparam longint SAMP_NS [8] = '{28000, 56000, 168000, 280000, 816000, 2280000,
                                      6220000, 11790000};
   localparam logic [7:0][18:0] SAMP_CYC = {
      19'(SAMP_NS[7] / CLK_PERIOD_NS), 19'(SAMP_NS[6] / CLK_PERIOD_NS),
      19'(SAMP_NS[5] / CLK_PERIOD_NS), 19'(SAMP_NS[4] / CLK_PERIOD_NS),
      19'(SAMP_NS[3] / CLK_PERIOD_NS), 19'(SAMP_NS[2] / CLK_PERIOD_NS),
      19'(SAMP_NS[1] / CLK_PERIOD_NS), 19'(SAMP_NS[0] / CLK_PERIOD_NS)};
   // ------------------------------------------------------------
   // Carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic half_duplex;
      logic tx_en;
      logic rx_dv;
   } ctd_gmii_s;
   typedef struct packed {
      logic [7:0] value;
      logic valid;
   } ctd_sensor_s;
   typedef struct packed {
      logic [1:0] avg_sel;
      logic [2:0] rate_sel;
      logic sample_tick;
      logic acquire;
   } ctd_sense_cfg_s;
endpackage

// file: design/ctd_regs.sv
// Copper test and diagnostics register bank with collision counters and temperature monitor
`timescale 1ns/1ns
module ctd_regs #(
   parameter longint POLL_SLOW = ctd_pkg::POLL_SLOW_CYC,
   parameter longint POLL_FAST = ctd_pkg::POLL_FAST_CYC,
   parameter logic [7:0][18:0] SAMPLE_CYC = ctd_pkg::SAMP_CYC
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [4:0] addr,
   input wire logic [15:0] wr_data,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [15:0] rd_data,
   input wire ctd_pkg::ctd_gmii_s gmii,
   input wire ctd_pkg::ctd_sensor_s sensor,
   input wire logic [1:0] manual_sel,
   output logic [8:0] ipg_bytes,
   output ctd_pkg::ctd_sense_cfg_s sense_cfg,
   output logic irq
);
   // ------------------------------------------------------------
   // Storage
   // ------------------------------------------------------------
   logic [15:0] gap_r;
   logic [15:0] win_r;
   logic [15:0] tctl_r;
   logic [15:0] talt_r;
   logic [7:0] lc_r [4];
   logic [7:0] tx_cnt_r;
   logic rx_dv_r;
   logic [7:0] temp_r;
   logic stat_r;
   logic irq_r;
   logic [8:0] ipg_r;
   logic [15:0] rd_data_r;
   logic [24:0] poll_cnt_r;
   logic [18:0] samp_cnt_r;
   logic acq_r;
   logic tick_r;
   logic poll_tick;
   logic sop;
   logic [8:0] byte_num;
   logic [2:0] bin;
   logic temp_hit;
   logic rd_tctl;
   logic [3:0] inc;
   logic [3:0] clr;

   // Returns {in window, counter index} for the transmit byte being sent
   function automatic logic [2:0] lc_bin(input logic [8:0] b, input logic [4:0] adj);
      logic [8:0] first;
      first = ctd_pkg::WIN1_FIRST - {4'h0, adj};
      if (b < first)
         lc_bin = 3'h0;
      else if (b <= ctd_pkg::WIN1_LAST)
         lc_bin = 3'h4;
      else if (b <= ctd_pkg::WIN2_LAST)
         lc_bin = 3'h5;
      else if (b <= ctd_pkg::WIN3_LAST)
         lc_bin = 3'h6;
      else
         lc_bin = 3'h7;
   endfunction

   function automatic logic hit_addr(input logic [4:0] a, input logic [4:0] r);
      hit_addr = (a == r);
   endfunction

   // ------------------------------------------------------------
   // Writable registers
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         gap_r <= ctd_pkg::GAP_RST;
         win_r <= ctd_pkg::WIN_RST;
         tctl_r <= ctd_pkg::TCTL_RST;
         talt_r <= ctd_pkg::TALT_RST;
      end else if (wr_en) begin
         if (hit_addr(addr, ctd_pkg::ADDR_GAP))
            gap_r <= wr_data;
         if (hit_addr(addr, ctd_pkg::ADDR_WIN))
            win_r <= wr_data;
         // Bit 15 is stored as written; keeping it at reset value is up to software
         if (hit_addr(addr, ctd_pkg::ADDR_TCTL))
            tctl_r <= wr_data & ctd_pkg::TCTL_WMASK;
         if (hit_addr(addr, ctd_pkg::ADDR_TALT))
            talt_r <= wr_data & ctd_pkg::TALT_WMASK;
      end
   end

   // ------------------------------------------------------------
   // Generator gap
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst)
         ipg_r <= 9'h000;
      else
         ipg_r <= {1'b0, gap_r[7:0]} + 9'h001; // RULE1
   end

   // ------------------------------------------------------------
   // Late collision detection at the internal byte interface
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         tx_cnt_r <= 8'h00;
         rx_dv_r <= 1'b0;
      end else begin
         rx_dv_r <= gmii.rx_dv;
         // Saturating: anything past byte 255 is still beyond the last bound
         if (!gmii.tx_en)
            tx_cnt_r <= 8'h00;
         else if (tx_cnt_r != 8'hff)
            tx_cnt_r <= tx_cnt_r + 8'h01; // RULE6
      end
   end

   assign byte_num = {1'b0, tx_cnt_r} + 9'h001;
   assign sop = gmii.rx_dv && !rx_dv_r && gmii.tx_en && gmii.half_duplex; // RULE6
   assign bin = lc_bin(byte_num, win_r[ctd_pkg::WIN_ADJ_LSB +: 5]); // RULE8

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_lc
         assign inc[gi] = sop && bin[2] && (bin[1:0] == 2'(gi)); // RULE2 RULE3 RULE4 RULE5
         assign clr[gi] = rd_en &&
            hit_addr(addr, (gi < 2) ? ctd_pkg::ADDR_LC_LO : ctd_pkg::ADDR_LC_HI);
         always_ff @(posedge clk) begin
            if (rst)
               lc_r[gi] <= 8'h00;
            else if (inc[gi] && clr[gi])
               lc_r[gi] <= 8'h01; // RULE21
            else if (inc[gi] && lc_r[gi] != 8'hff)
               lc_r[gi] <= lc_r[gi] + 8'h01; // RULE7
            else if (clr[gi])
               lc_r[gi] <= 8'h00; // RULE7
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // Temperature monitor
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst)
         temp_r <= 8'h00;
      else if (sensor.valid)
         temp_r <= sensor.value;
   end

   // Celsius cancels its 25 offset on both sides, so raw value meets five times field
   assign temp_hit = temp_r >= 8'(ctd_pkg::TEMP_MULT * {3'h0, tctl_r[ctd_pkg::THR_LSB +: 5]}); // RULE10
   assign rd_tctl = rd_en && hit_addr(addr, ctd_pkg::ADDR_TCTL);

   always_ff @(posedge clk) begin
      if (rst)
         stat_r <= 1'b0;
      else if (temp_hit)
         stat_r <= 1'b1; // RULE12 RULE20
      else if (rd_tctl)
         stat_r <= 1'b0; // RULE20
   end

   always_ff @(posedge clk) begin
      if (rst)
         irq_r <= 1'b0;
      else
         irq_r <= stat_r && tctl_r[ctd_pkg::IEN_BIT]; // RULE11 RULE19
   end

   // Poll timer; a slow rate of one second needs a wide counter
   always_ff @(posedge clk) begin
      if (rst || tctl_r[ctd_pkg::POLL_LSB + 1])
         poll_cnt_r <= 25'h0000000; // RULE9
      else if (poll_tick)
         poll_cnt_r <= 25'h0000000;
      else
         poll_cnt_r <= poll_cnt_r + 25'h0000001;
   end

   // A >= test: a switch from the slow to the fast rate may leave the count past the limit
   assign poll_tick = !tctl_r[ctd_pkg::POLL_LSB + 1] &&
      (poll_cnt_r >= ((tctl_r[ctd_pkg::POLL_LSB +: 2] == ctd_pkg::POLL_1S) ?
                      25'(POLL_SLOW - 1) : 25'(POLL_FAST - 1))); // RULE9

   always_ff @(posedge clk) begin
      if (rst)
         acq_r <= 1'b0;
      else if (manual_sel == ctd_pkg::MANUAL_SEL)
         acq_r <= tctl_r[ctd_pkg::MAN_BIT]; // RULE13
      else
         acq_r <= poll_tick;
   end

   // Sampling interval strobe for the sensor front end
   always_ff @(posedge clk) begin
      if (rst) begin
         samp_cnt_r <= 19'h00000;
         tick_r <= 1'b0;
      end else if (samp_cnt_r >= SAMPLE_CYC[talt_r[ctd_pkg::SRATE_LSB +: 3]] - 19'h00001) begin
         samp_cnt_r <= 19'h00000;
         tick_r <= 1'b1; // RULE16
      end else begin
         samp_cnt_r <= samp_cnt_r + 19'h00001;
         tick_r <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Read port
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst)
         rd_data_r <= 16'h0000;
      else if (rd_en) begin
         case (addr)
            ctd_pkg::ADDR_GAP: rd_data_r <= gap_r;
            ctd_pkg::ADDR_LC_LO: rd_data_r <= {lc_r[1], lc_r[0]};
            ctd_pkg::ADDR_LC_HI: rd_data_r <= {lc_r[3], lc_r[2]};
            ctd_pkg::ADDR_WIN: rd_data_r <= win_r;
            ctd_pkg::ADDR_TCTL: rd_data_r <= {tctl_r[15:7], stat_r, tctl_r[5], temp_r[5:1]}; // RULE14
            ctd_pkg::ADDR_TALT: rd_data_r <= {talt_r[15:8], temp_r}; // RULE17
            default: rd_data_r <= 16'h0000;
         endcase
      end
   end

   assign rd_data = rd_data_r;
   assign ipg_bytes = ipg_r;
   assign irq = irq_r;
   assign sense_cfg.avg_sel = talt_r[ctd_pkg::AVG_LSB +: 2]; // RULE15
   assign sense_cfg.rate_sel = talt_r[ctd_pkg::SRATE_LSB +: 3]; // RULE16
   assign sense_cfg.sample_tick = tick_r;
   assign sense_cfg.acquire = acq_r;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_sop_in(logic [8:0] lo, logic [8:0] hi);
      sop && byte_num >= lo && byte_num <= hi;
   endsequence
   sequence s_read_tctl;
      rd_en && addr == ctd_pkg::ADDR_TCTL;
   endsequence

   a_gap_plus_one: assert property ( // RULE1
      $changed(gap_r) |=> ipg_bytes == {1'b0, $past(gap_r[7:0])} + 9'h001)
      else $error("gap output not field plus one");
   a_first_window: assert property ( // RULE2
      s_sop_in(ctd_pkg::WIN1_FIRST - {4'h0, win_r[12:8]}, 9'h060) ##0 (!clr[0] && lc_r[0] != 8'hff)
      |=> lc_r[0] == $past(lc_r[0]) + 8'h01)
      else $error("first window counter missed");
   a_second_window: assert property ( // RULE3
      s_sop_in(9'h061, 9'h080) ##0 (!clr[1] && lc_r[1] != 8'hff) |=> lc_r[1] == $past(lc_r[1]) + 8'h01)
      else $error("second window counter missed");
   a_third_window: assert property ( // RULE4
      s_sop_in(9'h081, 9'h0c0) ##0 (!clr[2] && lc_r[2] != 8'hff) |=> lc_r[2] == $past(lc_r[2]) + 8'h01)
      else $error("third window counter missed");
   a_fourth_window: assert property ( // RULE5
      s_sop_in(9'h0c1, 9'h100) ##0 (!clr[3] && lc_r[3] != 8'hff) |=> lc_r[3] == $past(lc_r[3]) + 8'h01)
      else $error("fourth window counter missed");
   a_count_saturate: assert property ( // RULE7
      lc_r[3] == 8'hff && !clr[3] |=> lc_r[3] == 8'hff)
      else $error("counter wrapped");
   a_read_keeps_inc: assert property ( // RULE21
      inc[2] && clr[2] |=> lc_r[2] == 8'h01 ##1
      (!$past(rd_en) || $past(addr) != ctd_pkg::ADDR_LC_HI || rd_data[7:0] != 8'h00))
      else $error("increment lost on clearing read");
   a_status_clear: assert property ( // RULE20
      s_read_tctl ##0 !temp_hit |=> !stat_r)
      else $error("status not cleared by read");
   a_status_latch: assert property ( // RULE12
      temp_hit |=> stat_r ##1 (irq == tctl_r[ctd_pkg::IEN_BIT] || $changed(tctl_r)))
      else $error("status did not latch");
   a_irq_gate: assert property ( // RULE19
      irq |-> $past(stat_r) && $past(tctl_r[ctd_pkg::IEN_BIT]))
      else $error("interrupt without enabled status");
   a_poll_off: assert property ( // RULE9
      tctl_r[ctd_pkg::POLL_LSB + 1] && manual_sel != ctd_pkg::MANUAL_SEL [*2] |-> !sense_cfg.acquire)
      else $error("acquire while polling disabled");
   a_manual_acq: assert property ( // RULE13
      manual_sel == ctd_pkg::MANUAL_SEL |=> sense_cfg.acquire == $past(tctl_r[ctd_pkg::MAN_BIT]))
      else $error("manual acquire not followed");
   a_coarse_read: assert property ( // RULE14
      s_read_tctl |=> rd_data[4:0] == $past(temp_r[5:1]) && rd_data[6] == $past(stat_r))
      else $error("coarse temperature readout wrong");

   // ------------------------------------------------------------
   // Counter and register checks
   // ------------------------------------------------------------
   sequence s_read_at(logic [4:0] a);
      rd_en && addr == a;
   endsequence

   a_count_clear: assert property ( // RULE7
      s_read_at(ctd_pkg::ADDR_LC_LO) ##0 (inc[1:0] == 2'h0)
      |=> lc_r[0] == 8'h00 && lc_r[1] == 8'h00)
      else $error("counter not cleared by read");
   a_half_duplex_only: assert property ( // RULE6
      !gmii.half_duplex && !rd_en |=> lc_r[0] == $past(lc_r[0]) &&
      lc_r[1] == $past(lc_r[1]) && lc_r[2] == $past(lc_r[2]) && lc_r[3] == $past(lc_r[3]))
      else $error("count outside half duplex");
   a_below_window: assert property ( // RULE8
      sop && byte_num < ctd_pkg::WIN1_FIRST - {4'h0, win_r[ctd_pkg::WIN_ADJ_LSB +: 5]}
      |-> inc == 4'h0)
      else $error("count below window start");
   a_one_counter: assert property ( // RULE6
      $onehot0(inc))
      else $error("several counters bumped");
   a_gap_read: assert property ( // RULE1
      s_read_at(ctd_pkg::ADDR_GAP) |=> rd_data == $past(gap_r))
      else $error("gap register readback wrong");
   a_win_read: assert property ( // RULE8
      s_read_at(ctd_pkg::ADDR_WIN) |=> rd_data == $past(win_r))
      else $error("window register readback wrong");

   // ------------------------------------------------------------
   // Temperature and sensor checks
   // ------------------------------------------------------------
   // Interrupt trails status by one cycle because it leaves through a flip-flop
   a_irq_raise: assert property ( // RULE19
      stat_r && tctl_r[ctd_pkg::IEN_BIT] |=> irq)
      else $error("interrupt missing");
   a_irq_block: assert property ( // RULE11
      !tctl_r[ctd_pkg::IEN_BIT] |=> !irq)
      else $error("interrupt while disabled");
   a_status_hold: assert property ( // RULE12
      stat_r && !rd_tctl |=> stat_r)
      else $error("status dropped without read");
   a_alt_read: assert property ( // RULE17
      s_read_at(ctd_pkg::ADDR_TALT) |=> rd_data[7:0] == $past(temp_r))
      else $error("alternative temperature readout wrong");
   a_poll_pulse: assert property ( // RULE9
      manual_sel != ctd_pkg::MANUAL_SEL [*2] ##0 sense_cfg.acquire |=> !sense_cfg.acquire)
      else $error("poll acquire longer than one cycle");
   a_sample_pulse: assert property ( // RULE16
      sense_cfg.sample_tick |=> !sense_cfg.sample_tick)
      else $error("sample strobe longer than one cycle");
endmodule

// file: testbench/ctd_regs_test.sv
// Self-checking testbench for the copper test and diagnostics register bank
`timescale 1ns/1ns
module ctd_regs_test;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [4:0] addr = 5'h00;
   logic [15:0] wr_data = 16'h0000;
   logic wr_en = 1'b0;
   logic rd_en = 1'b0;
   logic [15:0] rd_data;
   ctd_pkg::ctd_gmii_s gmii = '0;
   ctd_pkg::ctd_sensor_s sensor = '0;
   logic [1:0] manual_sel = 2'h0;
   logic [8:0] ipg_bytes;
   ctd_pkg::ctd_sense_cfg_s sense_cfg;
   logic irq;
   int bad_count = 0;
   int checked = 0;
   int seed = 36967;
   int cnt [4] = '{0, 0, 0, 0};
   int na;
   int ns;
   logic [15:0] v;
   logic [7:0] t;
   logic latch = 1'b0;
   // Short sampling periods; each divides the 240-cycle counting window
   localparam int PER [8] = '{2, 3, 4, 5, 6, 8, 10, 12};

   ctd_regs #(.POLL_SLOW(20), .POLL_FAST(10),
      .SAMPLE_CYC({19'h0c, 19'h0a, 19'h08, 19'h06, 19'h05, 19'h04, 19'h03, 19'h02})) i_dut (
      .clk(clk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
      .rd_data(rd_data), .gmii(gmii), .sensor(sensor), .manual_sel(manual_sel),
      .ipg_bytes(ipg_bytes), .sense_cfg(sense_cfg), .irq(irq));

   initial begin
      forever #20 clk = ~clk;
   end

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic test_done;
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic wr(logic [4:0] a, logic [15:0] d);
      @(posedge clk);
      wr_en <= 1'b1;
      addr <= a;
      wr_data <= d;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask

   task automatic rchk(string name, logic [4:0] a, logic [15:0] exp);
      @(posedge clk);
      rd_en <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd_en <= 1'b0;
      #1;
      check(name, rd_data, exp);
   endtask

   function automatic int bin(int b, int adj);
      if (b > 192) return 3;
      if (b > 128) return 2;
      if (b > 96) return 1;
      if (b >= 65 - adj) return 0;
      return -1;
   endfunction

   // Receive start is raised so that it is first seen on transmit byte b
   task automatic coll(int b, logic hd, int adj);
      int k;
      k = bin(b, adj);
      gmii.half_duplex <= hd;
      @(posedge clk);
      gmii.tx_en <= 1'b1;
      repeat (b - 1) @(posedge clk);
      gmii.rx_dv <= 1'b1;
      @(posedge clk);
      gmii.tx_en <= 1'b0;
      gmii.rx_dv <= 1'b0;
      repeat (3) @(posedge clk);
      if (hd && k >= 0 && cnt[k] < 255) cnt[k]++;
   endtask

   task automatic chk_cnt;
      rchk("late counts low", ctd_pkg::ADDR_LC_LO, {8'(cnt[1]), 8'(cnt[0])});
      rchk("late counts high", ctd_pkg::ADDR_LC_HI, {8'(cnt[3]), 8'(cnt[2])});
      cnt = '{0, 0, 0, 0};
   endtask

   task automatic heat(logic [7:0] val);
      @(posedge clk);
      sensor.value <= val;
      sensor.valid <= 1'b1;
      @(posedge clk);
      sensor.valid <= 1'b0;
      repeat (3) @(posedge clk);
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      check("gap bytes", 16'(ipg_bytes), 16'h000d);
      rchk("gap reg", ctd_pkg::ADDR_GAP, 16'h000c);
      rchk("window reg", ctd_pkg::ADDR_WIN, 16'h0000);
      rchk("temp ctl", ctd_pkg::ADDR_TCTL, 16'h1900);
      rchk("temp alt", ctd_pkg::ADDR_TALT, 16'h0c00);
      rchk("unmapped", 5'h00, 16'h0000);
      chk_cnt();
      $display("test reset done");

      for (int i = 0; i < 5; i++) begin
         v = (i == 0) ? 16'h00ff : 16'($random(seed));
         wr(ctd_pkg::ADDR_GAP, v);
         repeat (2) @(posedge clk);
         check("gap bytes", 16'(ipg_bytes), 16'(v[7:0]) + 16'h0001);
         rchk("gap reg", ctd_pkg::ADDR_GAP, v);
      end
      $display("test gap done");

      foreach (PER[i]) coll(64 + i * 0, 1'b1, 0);
      for (int i = 0; i < 8; i++) begin
         coll(i[0] ? 1 + 32 * (i + 1) - 32 : 64 + 32 * (i / 2) + 1, 1'b1, 0);
      end
      coll(96, 1'b1, 0);
      coll(128, 1'b1, 0);
      coll(192, 1'b1, 0);
      coll(100, 1'b0, 0);
      for (int i = 0; i < 10; i++) coll(1 + ({$random(seed)} % 255), 1'b1, 0);
      chk_cnt();
      wr(ctd_pkg::ADDR_WIN, 16'h1f00);
      coll(33, 1'b1, 31);
      coll(34, 1'b1, 31);
      chk_cnt();
      rchk("late counts cleared", ctd_pkg::ADDR_LC_LO, 16'h0000);
      gmii.half_duplex <= 1'b1;
      gmii.tx_en <= 1'b1;
      repeat (260) @(posedge clk);
      repeat (300) begin
         gmii.rx_dv <= 1'b1;
         @(posedge clk);
         gmii.rx_dv <= 1'b0;
         @(posedge clk);
      end
      gmii.tx_en <= 1'b0;
      repeat (3) @(posedge clk);
      rchk("late count sat", ctd_pkg::ADDR_LC_HI, 16'hff00);
      rchk("late count clear", ctd_pkg::ADDR_LC_HI, 16'h0000);
      // Receive start on byte 150 lands on the same edge as a clearing read
      gmii.tx_en <= 1'b1;
      repeat (149) @(posedge clk);
      gmii.rx_dv <= 1'b1;
      rd_en <= 1'b1;
      addr <= ctd_pkg::ADDR_LC_HI;
      @(posedge clk);
      gmii.tx_en <= 1'b0;
      gmii.rx_dv <= 1'b0;
      rd_en <= 1'b0;
      #1;
      check("read beside count", rd_data, 16'h0000);
      rchk("count kept", ctd_pkg::ADDR_LC_HI, 16'h0001);
      $display("test collisions done");

      wr(ctd_pkg::ADDR_TCTL, 16'h1980);
      for (int i = 0; i < 8; i++) begin
         t = (i < 2) ? 8'(125 - i) : 8'(115 + ({$random(seed)} % 20));
         heat(t);
         latch = latch | (t >= 8'd125);
         check("irq", 16'(irq), 16'(latch));
         rchk("temp ctl", ctd_pkg::ADDR_TCTL, 16'h1980 | 16'(latch) << 6 | 16'(t[5:1]));
         rchk("temp alt", ctd_pkg::ADDR_TALT, 16'h0c00 | 16'(t));
         latch = (t >= 8'd125);
         check("irq after read", 16'(irq), 16'(latch));
      end
      heat(8'd125);
      wr(ctd_pkg::ADDR_TCTL, 16'h1900);
      repeat (3) @(posedge clk);
      check("irq masked", 16'(irq), 16'h0000);
      $display("test temperature done");

      for (int k = 0; k < 8; k++) begin
         wr(ctd_pkg::ADDR_TALT, {3'h0, 2'(k), 3'(k), 8'h00});
         wr(ctd_pkg::ADDR_TCTL, {1'b0, 2'(k), 5'h19, 8'h00});
         check("avg sel", 16'(sense_cfg.avg_sel), 16'(k % 4));
         check("rate sel", 16'(sense_cfg.rate_sel), 16'(k));
         repeat (40) @(posedge clk);
         na = 0;
         ns = 0;
         repeat (240) begin
            @(posedge clk);
            #1;
            na += int'(sense_cfg.acquire);
            ns += int'(sense_cfg.sample_tick);
         end
         check("poll pulses", 16'(na), (k % 4 > 1) ? 16'h0000 : (k % 2 ? 16'h0018 : 16'h000c));
         check("sample ticks", 16'(ns), 16'(240 / PER[k]));
      end
      manual_sel <= 2'h2;
      wr(ctd_pkg::ADDR_TCTL, 16'h7920);
      repeat (3) @(posedge clk);
      check("manual acquire", 16'(sense_cfg.acquire), 16'h0001);
      manual_sel <= 2'h1;
      repeat (3) @(posedge clk);
      check("manual off", 16'(sense_cfg.acquire), 16'h0000);
      $display("test sensor control done");
      test_done();
   end

   initial begin
      repeat (30000) @(posedge clk);
      bad_count++;
      $display("Error watchdog expected finish seen timeout");
      test_done();
   end
endmodule
